// ### verilog/keypad_level_wakeup_input.sv
// Design: single keypad input with level detection, status flag and wake-up
//
// Contract
// - Level-select 1 detects high, 0 detects low
// - Hardware sets flag while input matches level
// - Reading status register clears the flag
// - Flag set requests keyboard interrupt
// - Mask bit 1 blocks the interrupt
// - Global enable gates keyboard interrupt entirely
// - Power-down exit enable permits power-down wake
// - Key event also wakes from idle
// - Power-down detection is asynchronous, spurious wakes possible
// - Status bits 6..1 always read zero
// - Control register resets to 0000 1111
// - Status register resets to all zeros
`timescale 1ns/100ps

module keypad_level_wakeup_input (
  input wire logic mclk,
  input wire logic reset_n,
  input wire keypad_pkg::sfr_req_s sfrReq,
  output logic [7:0] sfrRdData,
  input wire logic keyInputPin,
  input wire logic keypadIrqGlobalEnable,
  input wire logic powerDownActive,
  output logic keypadIrq,
  output logic wakeFromIdle,
  output logic wakeFromPowerDown
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] keypadControl_r;
  logic [7:0] keypadControl_nxt;
  logic keyPowerdownExitEnable_r;
  logic keyPowerdownExitEnable_nxt;
  logic keyInputFlag_r;
  logic keyInputFlag_nxt;
  logic [7:1] auxUpper_r;
  logic [7:1] auxUpper_nxt;
  logic [7:0] sfrRdData_nxt;
  logic [keypad_pkg::SYNC_STAGES-1:0] keySync_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic selAux = (sfrReq.addr == keypad_pkg::AUX_CTRL_ADDR);
  wire logic selCtrl = (sfrReq.addr == keypad_pkg::KEY_CTRL_ADDR);
  wire logic selStat = (sfrReq.addr == keypad_pkg::KEY_STAT_ADDR);
  wire logic wrAux = sfrReq.wr & selAux;
  wire logic wrCtrl = sfrReq.wr & selCtrl;
  wire logic wrStat = sfrReq.wr & selStat;
  wire logic rdStat = sfrReq.rd & selStat;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  wire logic keyLevelSelect = keypadControl_r[keypad_pkg::CTRL_LEVEL_BIT];
  wire logic keyIrqMask = keypadControl_r[keypad_pkg::CTRL_MASK_BIT];

  // ---------------------------------------------------------------
  // Level detection
  // ---------------------------------------------------------------
  // Only the last synchroniser stage is compared; the first stage may be metastable
  wire logic keySynced = keySync_r[keypad_pkg::SYNC_STAGES-1];
  wire logic levelMatchSync = (keySynced == keyLevelSelect);
  // Raw compare for power-down, where no clock edge will come to sample
  wire logic levelMatchRaw = (keyInputPin == keyLevelSelect);

  // ---------------------------------------------------------------
  // Status byte assembled for reads; bits 6..1 are forced to zero
  // ---------------------------------------------------------------
  wire logic [7:0] statusView = {keyPowerdownExitEnable_r, 6'h00, keyInputFlag_r};
  wire logic [7:0] auxView = {auxUpper_r, keySynced};

  // ---------------------------------------------------------------
  // Interrupt and wake-up
  // ---------------------------------------------------------------
  // Level request: stays up while the flag is set, unmasked and globally enabled
  wire logic irqAllowed = ~keyIrqMask & keypadIrqGlobalEnable;
  assign keypadIrq = keyInputFlag_r & irqAllowed;
  // Idle keeps the clock alive, so the registered request is enough
  assign wakeFromIdle = keypadIrq;
  // Power-down stops mclk: the pin is watched combinationally, so a
  // bounce can wake the core with no key stored; firmware must recheck
  assign wakeFromPowerDown = powerDownActive & keyPowerdownExitEnable_r & irqAllowed & levelMatchRaw;

  // ---------------------------------------------------------------
  // Next-state logic for the registers
  // ---------------------------------------------------------------
  // Control keeps all eight bits as written; reserved bits are the caller's duty
  assign keypadControl_nxt = wrCtrl ? sfrReq.wrData : keypadControl_r;
  assign keyPowerdownExitEnable_nxt = wrStat ? sfrReq.wrData[keypad_pkg::STAT_PDE_BIT] : keyPowerdownExitEnable_r;
  // Set wins over the read clear so a key seen during the read is kept
  assign keyInputFlag_nxt = levelMatchSync ? 1'b1 : (rdStat ? 1'b0 : keyInputFlag_r);
  // Upper auxiliary bits belong to other blocks; held here as plain storage
  assign auxUpper_nxt = wrAux ? sfrReq.wrData[7:1] : auxUpper_r;

  // ---------------------------------------------------------------
  // Read mux; unmapped addresses answer zero
  // ---------------------------------------------------------------
  assign sfrRdData_nxt = !sfrReq.rd ? sfrRdData :
                         selCtrl ? keypadControl_r :
                         selStat ? statusView :
                         selAux ? auxView : 8'h00;

  // ---------------------------------------------------------------
  // Synchroniser on the key pin
  // ---------------------------------------------------------------
  // Two flops trade one extra cycle of latency for metastability margin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Preset to the pin's idle level so no false match follows reset
      keySync_r <= {keypad_pkg::SYNC_STAGES{keypad_pkg::AUX_CTRL_RESET[keypad_pkg::AUX_KEY_PIN_BIT]}};
    end else begin
      keySync_r <= {keySync_r[keypad_pkg::SYNC_STAGES-2:0], keyInputPin};
    end
  end

  // ---------------------------------------------------------------
  // Control and auxiliary registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      keypadControl_r <= keypad_pkg::KEY_CTRL_RESET;
      auxUpper_r <= keypad_pkg::AUX_CTRL_RESET[7:1];
    end else begin
      keypadControl_r <= keypadControl_nxt;
      auxUpper_r <= auxUpper_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      keyPowerdownExitEnable_r <= keypad_pkg::KEY_STAT_RESET[keypad_pkg::STAT_PDE_BIT];
      keyInputFlag_r <= keypad_pkg::KEY_STAT_RESET[keypad_pkg::STAT_FLAG_BIT];
    end else begin
      keyPowerdownExitEnable_r <= keyPowerdownExitEnable_nxt;
      keyInputFlag_r <= keyInputFlag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read data register
  // ---------------------------------------------------------------
  // Registered so the core sees stable data one cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdData <= 8'h00;
    end else begin
      sfrRdData <= sfrRdData_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertion helper: run length of the synchronised match
  // ---------------------------------------------------------------
  // Saturates at seven so a long press never wraps back to zero
  logic [2:0] matchRun_r;
  wire logic [2:0] matchRun_nxt = !levelMatchSync ? 3'h0 :
                                  (matchRun_r == 3'h7) ? matchRun_r : matchRun_r + 3'h1;

  // Counter serves the checks only; no output depends on it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      matchRun_r <= 3'h0;
    end else begin
      matchRun_r <= matchRun_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Pin held at the selected level for three cycles, level unchanged
  sequence keyHeldAtLevel;
    (keyInputPin == keyLevelSelect && !wrCtrl)[*3];
  endsequence

  // Status read with no match arriving at the same edge
  sequence quietStatusRead;
    rdStat && !levelMatchSync;
  endsequence

  // Two edges after release: status at its reset value, no false set
  sequence resetSettled;
    (!keyPowerdownExitEnable_r && !keyInputFlag_r) ##1 !keyInputFlag_r;
  endsequence

  // Press walk: a synchronised match, then the flag on the next edge
  sequence pressThroughSync;
    levelMatchSync ##1 keyInputFlag_r;
  endsequence

  chk_flag_after_sync: assert property (keyHeldAtLevel |=> ##1 keyInputFlag_r)
    else $error("flag not set after key held at level");

  chk_sync_two_stage: assert property ($rose(keyInputFlag_r) |-> $past(keyInputPin, 3) == $past(keyLevelSelect, 1))
    else $error("flag rose without synchronised level match");

  chk_level_high_low: assert property (keySynced != keyLevelSelect && !keyInputFlag_r |=> !keyInputFlag_r)
    else $error("level compare ignores level select");

  chk_read_clears_flag: assert property (quietStatusRead |=> !keyInputFlag_r)
    else $error("status read did not clear flag");

  chk_set_beats_clear: assert property (rdStat && levelMatchSync |=> keyInputFlag_r)
    else $error("read clear lost a simultaneous set");

  chk_irq_on_flag: assert property ($rose(keyInputFlag_r) && !keyIrqMask && keypadIrqGlobalEnable |-> keypadIrq)
    else $error("no interrupt when flag set");

  chk_mask_blocks_irq: assert property (keyIrqMask |-> !keypadIrq && !wakeFromIdle)
    else $error("masked flag raised interrupt");

  chk_global_gate_irq: assert property (!keypadIrqGlobalEnable |-> !keypadIrq && !wakeFromPowerDown)
    else $error("interrupt raised while globally disabled");

  chk_powerdown_enable: assert property (wakeFromPowerDown |-> keyPowerdownExitEnable_r && powerDownActive)
    else $error("power-down wake without exit enable");

  chk_idle_wake: assert property (keypadIrq |-> wakeFromIdle)
    else $error("interrupt did not wake from idle");

  chk_status_reserved: assert property (rdStat |=> sfrRdData[6:1] == 6'h00 && sfrRdData[0] == $past(keyInputFlag_r))
    else $error("status reserved bits not zero");

  chk_ctrl_readback: assert property (sfrReq.rd && selCtrl |=> sfrRdData == $past(keypadControl_r))
    else $error("control read back wrong");

  // ---------------------------------------------------------------
  // Assertions: reset values and register port
  // ---------------------------------------------------------------

  chk_ctrl_reset_value: assert property ($rose(reset_n) |-> keypadControl_r == keypad_pkg::KEY_CTRL_RESET)
    else $error("control not at reset value after release");

  chk_stat_reset_value: assert property ($rose(reset_n) |-> resetSettled)
    else $error("status not clear after release");

  chk_ctrl_write_lands: assert property (wrCtrl |=> keypadControl_r == $past(sfrReq.wrData))
    else $error("control write lost");

  chk_pde_write_lands: assert property (wrStat |=> keyPowerdownExitEnable_r == $past(sfrReq.wrData[7]))
    else $error("exit enable write lost");

  chk_stat_pde_bit: assert property (rdStat |=> sfrRdData[7] == $past(keyPowerdownExitEnable_r))
    else $error("status read shows wrong exit enable");

  chk_aux_pin_bit: assert property (sfrReq.rd && selAux |=> sfrRdData[0] == $past(keySynced))
    else $error("aux read shows wrong pin level");

  // ---------------------------------------------------------------
  // Assertions: key path, interrupt and wake-up
  // ---------------------------------------------------------------

  chk_only_read_clears: assert property ($fell(keyInputFlag_r) |-> $past(rdStat))
    else $error("flag cleared without status read");

  chk_flag_while_held: assert property (matchRun_r != 3'h0 |-> keyInputFlag_r)
    else $error("flag clear while level held");

  chk_match_sets_flag: assert property (levelMatchSync |-> pressThroughSync)
    else $error("match did not set flag");

  chk_flag_holds_set: assert property (keyInputFlag_r && !rdStat |=> keyInputFlag_r)
    else $error("flag dropped with no status read");

  chk_irq_needs_flag: assert property (!keyInputFlag_r |-> !keypadIrq)
    else $error("interrupt with flag clear");

  chk_irq_enabled_flag: assert property (keyInputFlag_r && !keyIrqMask && keypadIrqGlobalEnable |-> keypadIrq)
    else $error("enabled flag raised no interrupt");

  chk_idle_wake_irq: assert property (wakeFromIdle |-> keypadIrq)
    else $error("idle wake without interrupt");

  chk_mask_blocks_wake: assert property (keyIrqMask |-> !wakeFromPowerDown)
    else $error("masked flag woke from power-down");

  chk_wake_needs_pd: assert property (!powerDownActive |-> !wakeFromPowerDown)
    else $error("power-down wake while running");

  chk_wake_exit_disabled: assert property (!keyPowerdownExitEnable_r |-> !wakeFromPowerDown)
    else $error("power-down wake with exit disabled");

  chk_wake_on_level: assert property (powerDownActive && keyPowerdownExitEnable_r && !keyIrqMask
      && keypadIrqGlobalEnable && keyInputPin == keyLevelSelect |-> wakeFromPowerDown)
    else $error("power-down wake missed at level");

  chk_wake_raw_pin: assert property (wakeFromPowerDown |-> keyInputPin == keyLevelSelect)
    else $error("power-down wake off level");

endmodule

// ### shared/keypad_pkg.sv
// Package: register map, field positions and reset values of the keypad input
package keypad_pkg;

  // ---------------------------------------------------------------
  // Register offsets on the special function register port
  // ---------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_ADDR = 8'h90;
  localparam logic [7:0] KEY_CTRL_ADDR = 8'hA3;
  localparam logic [7:0] KEY_STAT_ADDR = 8'hA4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AUX_KEY_PIN_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 4;
  localparam int CTRL_MASK_BIT = 0;
  localparam int STAT_PDE_BIT = 7;
  localparam int STAT_FLAG_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_RESET = 8'hFF;
  localparam logic [7:0] KEY_CTRL_RESET = 8'h0F;
  localparam logic [7:0] KEY_STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_RESERVED_MASK = 8'h7E;

  // ---------------------------------------------------------------
  // Synchroniser depth while clocks run
  // ---------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Carrier for one register access from the core
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } sfr_req_s;

endpackage

// ### bench/keypad_model.sv
// Partner model: key switch with pull resistor on the keypad input
`timescale 1ns/100ps

module keypad_model (
  input wire logic pressed,
  input wire logic activeHigh,
  output logic keyInputPin
);
  // ---------------------------------------------------------------
  // Switch contact
  // ---------------------------------------------------------------
  // A released key leaves the pull resistor at the inactive level
  assign keyInputPin = pressed ? activeHigh : ~activeHigh;
endmodule

// ### bench/keypad_level_wakeup_input_tb.sv
// Testbench: level detection, flag clear, interrupt gating and wake-up of the keypad input
`timescale 1ns/100ps

module keypad_level_wakeup_input_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  keypad_pkg::sfr_req_s sfrReq = '0;
  logic [7:0] sfrRdData;
  logic keyInputPin;
  logic pressed = 1'b0;
  logic activeHigh = 1'b0;
  logic gie = 1'b1;
  logic pdActive = 1'b0;
  logic keypadIrq, wakeFromIdle, wakeFromPowerDown;
  logic lvl, msk;
  int failures = 0;
  int cmp_count = 0;
  // Bench model of the registers
  logic [7:0] ctrlM = 8'h0F;
  logic pdeM = 1'b0;
  logic flagM = 1'b0;

  // ---------------------------------------------------------------
  // Clock, parts and watchdog
  // ---------------------------------------------------------------
  always #50 mclk = ~mclk;
  keypad_model pad (.pressed(pressed), .activeHigh(activeHigh), .keyInputPin(keyInputPin));
  keypad_level_wakeup_input dut (.mclk(mclk), .reset_n(reset_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .keyInputPin(keyInputPin), .keypadIrqGlobalEnable(gie), .powerDownActive(pdActive),
    .keypadIrq(keypadIrq), .wakeFromIdle(wakeFromIdle), .wakeFromPowerDown(wakeFromPowerDown));
  // Whole run needs well under 1000 cycles
  initial begin
    #(3000 * 100);
    failures++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask
  // One access, strobes held for exactly one rising edge
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, input logic r);
    @(negedge mclk);
    sfrReq = '{addr: a, wrData: d, wr: w, rd: r};
    @(negedge mclk);
    sfrReq.wr = 1'b0;
    sfrReq.rd = 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string name);
    access(a, 1'b0, 8'h00, 1'b1);
    check(name, exp, sfrRdData);
  endtask
  // Status read from the model, then the flag clears unless the key still matches
  task automatic rdStat();
    rdChk(keypad_pkg::KEY_STAT_ADDR, {pdeM, 6'h00, flagM}, "status");
    flagM = pressed;
  endtask
  function automatic logic expIrq();
    return flagM & ~ctrlM[0] & gie;
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h163E));
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    rdChk(keypad_pkg::KEY_CTRL_ADDR, 8'h0F, "control");
    rdChk(keypad_pkg::KEY_STAT_ADDR, 8'h00, "status");
    rdChk(keypad_pkg::AUX_CTRL_ADDR, 8'hFF, "aux");
    rdChk(8'h55, 8'h00, "unmapped");
    access(keypad_pkg::AUX_CTRL_ADDR, 1'b1, 8'h54, 1'b0);
    rdChk(keypad_pkg::AUX_CTRL_ADDR, 8'h55, "aux write");
    $display("test reset done");
    // Random level, mask and global enable combinations
    for (int i = 0; i < 10; i++) begin
      lvl = 1'($urandom);
      msk = 1'($urandom);
      gie = 1'($urandom);
      ctrlM = {3'h0, lvl, 3'h7, msk};
      activeHigh = lvl;
      access(keypad_pkg::KEY_CTRL_ADDR, 1'b1, ctrlM, 1'b0);
      rdChk(keypad_pkg::KEY_CTRL_ADDR, ctrlM, "control write");
      // Synchroniser may still carry the old pin level
      repeat (4) @(negedge mclk);
      access(keypad_pkg::KEY_STAT_ADDR, 1'b0, 8'h00, 1'b1);
      rdStat();
      pressed = 1'b1;
      repeat (2) @(negedge mclk);
      check("irq early", 8'h00, {7'h00, keypadIrq});
      @(negedge mclk);
      flagM = 1'b1;
      check("irq", {7'h00, expIrq()}, {7'h00, keypadIrq});
      check("idle wake", {7'h00, expIrq()}, {7'h00, wakeFromIdle});
      rdStat();
      pressed = 1'b0;
      repeat (4) @(negedge mclk);
      rdStat();
      rdStat();
      check("irq clear", 8'h00, {7'h00, keypadIrq});
    end
    $display("test level detect done");
    // Power-down exit on a spurious contact
    gie = 1'b1;
    activeHigh = 1'b0;
    ctrlM = 8'h0E;
    access(keypad_pkg::KEY_CTRL_ADDR, 1'b1, ctrlM, 1'b0);
    access(keypad_pkg::KEY_STAT_ADDR, 1'b1, 8'hFF, 1'b0);
    pdeM = 1'b1;
    rdChk(keypad_pkg::KEY_STAT_ADDR, 8'h80, "status pde");
    pdActive = 1'b1;
    @(negedge mclk);
    pressed = 1'b1;
    #1 check("pd wake", 8'h01, {7'h00, wakeFromPowerDown});
    check("pd no flag", 8'h00, {7'h00, keypadIrq});
    pdActive = 1'b0;
    pressed = 1'b0;
    repeat (4) @(negedge mclk);
    // A contact shorter than a clock leaves no key behind
    rdStat();
    // No key found after the wake, so power-down is entered again
    pdActive = 1'b1;
    #1 check("pd idle", 8'h00, {7'h00, wakeFromPowerDown});
    access(keypad_pkg::KEY_STAT_ADDR, 1'b1, 8'h00, 1'b0);
    pdeM = 1'b0;
    @(negedge mclk);
    pressed = 1'b1;
    #1 check("pd blocked", 8'h00, {7'h00, wakeFromPowerDown});
    $display("test power-down done");
    test_done();
  end
endmodule
